// ===== rtl/edc_device_cap.sv
// The AHB-Lite register port was left to the implementer.
`timescale 1ns/10ps
`include "edc_cfg.svh"
// Summary of operation
// - Payload code bits 2:0, 256 bytes at reset
// - Phantom bits 4:3 read zero, ignore writes
// - Bit 5 reads one: eight-bit tags
// - L0s latency bits 8:6, zero at reset
// - L1 latency bits 11:9, zero at reset
// - Bit 12 one when hot-plug forward
// - Bits 13, 14 likewise follow hot-plug forward
// - Bits 25:18 take message power value
// - Bits 27:26 take message power scale
// - Forward is port type 7, reverse 8
module edc_device_cap #(
	parameter logic [2:0] MPS_CODE = `EDC_MPS_RST,  // Supported payload code
	parameter logic [2:0] L0S_CODE = `EDC_L0S_RST,  // Acceptable L0s exit latency code
	parameter logic [2:0] L1_CODE  = `EDC_L1_RST    // Acceptable L1 exit latency code
) (
	input  wire logic        clk_sys_i,      // Core clock, 100 MHz
	input  wire logic        rst_n_i,        // Device reset, active low
	input  wire logic        hp_strap_i,     // Hot-plug enable strap
	input  wire logic        reverse_i,      // High when bridge works in reverse orientation
	input  wire logic        spl_valid_i,    // One-cycle pulse: power limit message received
	input  wire logic [7:0]  spl_value_i,    // Power limit value of that message
	input  wire logic [1:0]  spl_scale_i,    // Power limit scale of that message
	output logic       [3:0] port_type_o,    // Port type code for the capability header
	input  wire logic        hsel_i,         // AHB-Lite slave select
	input  wire logic [31:0] haddr_i,        // AHB-Lite address
	input  wire logic [1:0]  htrans_i,       // AHB-Lite transfer type
	input  wire logic        hwrite_i,       // AHB-Lite write
	input  wire logic [2:0]  hsize_i,        // AHB-Lite size
	input  wire logic [31:0] hwdata_i,       // AHB-Lite write data, ignored
	input  wire logic        hready_i,       // AHB-Lite bus ready
	output logic       [31:0] hrdata_o,      // AHB-Lite read data
	output logic             hreadyout_o,    // AHB-Lite ready out
	output logic             hresp_o         // AHB-Lite response
);
	// Elaboration check: codes 6 and 7 are reserved payload sizes
	if (MPS_CODE > 3'h5) begin : g_bad_mps
		$error("Payload code above 4096 bytes is reserved");
	end

	// ----------------------------------------
	// Strap capture
	// ----------------------------------------
	// Strap is caught after reset release, not under the asynchronous reset
	logic strap_done_r;
	logic strap_done_nxt;
	logic hp_fwd_r;        // Hot-plug enabled in forward orientation
	logic hp_fwd_nxt;
	logic reverse_r;       // Orientation latched with the strap
	logic reverse_nxt;

	// Next strap values: capture once, then hold
	always_comb begin
		strap_done_nxt = 1'b1;
		hp_fwd_nxt     = hp_fwd_r;
		reverse_nxt    = reverse_r;
		if (!strap_done_r) begin
			hp_fwd_nxt  = hp_strap_i & ~reverse_i;
			reverse_nxt = reverse_i;
		end
	end

	// Strap registers
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			strap_done_r <= 1'b0;
			hp_fwd_r     <= 1'b0;
			reverse_r    <= 1'b0;
		end else begin
			strap_done_r <= strap_done_nxt;
			hp_fwd_r     <= hp_fwd_nxt;
			reverse_r    <= reverse_nxt;
		end
	end

	// Port type follows the orientation
	logic [3:0] port_type_nxt;
	logic [3:0] port_type_r;
	always_comb begin
		port_type_nxt = reverse_nxt ? `EDC_PT_REVERSE : `EDC_PT_FORWARD;
	end
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			port_type_r <= `EDC_PT_FORWARD;
		end else begin
			port_type_r <= port_type_nxt;
		end
	end
	assign port_type_o = port_type_r;

	// ----------------------------------------
	// Slot power limit capture
	// ----------------------------------------
	edc_pkg::edc_spl_s spl_r;
	edc_pkg::edc_spl_s spl_nxt;

	// Every received message overwrites the previous capture
	always_comb begin
		spl_nxt = spl_r;
		if (spl_valid_i) begin
			spl_nxt.value = spl_value_i;
			spl_nxt.scale = spl_scale_i;
		end
	end
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			spl_r.value <= `EDC_SPL_VAL_RST;
			spl_r.scale <= `EDC_SPL_SCL_RST;
		end else begin
			spl_r <= spl_nxt;
		end
	end

	// ----------------------------------------
	// Capability word assembly
	// ----------------------------------------
	logic [31:0] cap_word;
	always_comb begin
		cap_word = 32'h0000_0000;
		cap_word[`EDC_MPS_LSB +: 3]     = MPS_CODE;
		cap_word[`EDC_PHANTOM_LSB +: 2] = `EDC_PHANTOM_RST;
		cap_word[`EDC_TAG8_BIT]         = `EDC_TAG8_RST;
		cap_word[`EDC_L0S_LSB +: 3]     = L0S_CODE;
		cap_word[`EDC_L1_LSB +: 3]      = L1_CODE;
		cap_word[`EDC_BUTTON_BIT]       = hp_fwd_r;
		cap_word[`EDC_ATT_IND_BIT]      = hp_fwd_r;
		cap_word[`EDC_PWR_IND_BIT]      = hp_fwd_r;
		cap_word[`EDC_SPL_VAL_LSB +: 8] = spl_r.value;
		cap_word[`EDC_SPL_SCL_LSB +: 2] = spl_r.scale;
	end

	// ----------------------------------------
	// AHB-Lite slave
	// ----------------------------------------
	// Zero wait states; writes are accepted and discarded
	edc_pkg::edc_phase_e phase_r;
	edc_pkg::edc_phase_e phase_nxt;
	logic [31:0]         rdata_r;
	logic [31:0]         rdata_nxt;
	logic                hit;      // Address decodes to the capability word

	always_comb begin
		hit       = (haddr_i[`EDC_ADDR_BITS-1:0] == `EDC_CAP_WORD_OFS) &&
		            (haddr_i[31:`EDC_ADDR_BITS] == 24'h00_0000);
		phase_nxt = edc_pkg::EDC_IDLE;
		rdata_nxt = 32'h0000_0000;
		if (hsel_i && hready_i && htrans_i[1]) begin
			if (hwrite_i) begin
				phase_nxt = edc_pkg::EDC_WRITE;
			end else begin
				phase_nxt = edc_pkg::EDC_READ;
				// Unmapped addresses read zero
				if (hit) begin
					rdata_nxt = cap_word;
				end
			end
		end
	end
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			phase_r <= edc_pkg::EDC_IDLE;
			rdata_r <= 32'h0000_0000;
		end else begin
			phase_r <= phase_nxt;
			rdata_r <= rdata_nxt;
		end
	end
	assign hrdata_o    = rdata_r;
	assign hreadyout_o = 1'b1;
	assign hresp_o     = 1'b0;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	property p_mps;
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		(phase_r == edc_pkg::EDC_READ) && $past(hit) |-> hrdata_o[2:0] == MPS_CODE;
	endproperty
	a_mps: assert property (p_mps) else $error("Payload code wrong");

	property p_phantom;
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		(phase_r == edc_pkg::EDC_READ) |-> hrdata_o[4:3] == 2'h0;
	endproperty
	a_phantom: assert property (p_phantom) else $error("Phantom bits not zero");

	property p_tag;
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		(phase_r == edc_pkg::EDC_READ) |-> hrdata_o[5] == $past(hit);
	endproperty
	a_tag: assert property (p_tag) else $error("Tag bit wrong");

	property p_lat;
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		(phase_r == edc_pkg::EDC_READ) && $past(hit) |-> hrdata_o[11:6] == {L1_CODE, L0S_CODE};
	endproperty
	a_lat: assert property (p_lat) else $error("Latency codes wrong");

	property p_hp;
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		$rose(strap_done_r) |-> hp_fwd_r == $past(hp_strap_i & ~reverse_i);
	endproperty
	a_hp: assert property (p_hp) else $error("Hot-plug capture wrong");

	property p_hp_bits;
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		(phase_r == edc_pkg::EDC_READ) && $past(hit) |-> hrdata_o[14:12] == {3{$past(hp_fwd_r)}};
	endproperty
	a_hp_bits: assert property (p_hp_bits) else $error("Hot-plug bits wrong");

	property p_spl;
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		spl_valid_i |=> spl_r == {$past(spl_value_i), $past(spl_scale_i)};
	endproperty
	a_spl: assert property (p_spl) else $error("Power limit not captured");

	property p_spl_hold;
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		!spl_valid_i |=> $stable(spl_r.scale);
	endproperty
	a_spl_hold: assert property (p_spl_hold) else $error("Power scale changed");

	property p_ptype;
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		strap_done_r |-> port_type_o == (reverse_r ? 4'h8 : 4'h7);
	endproperty
	a_ptype: assert property (p_ptype) else $error("Port type wrong");

	property p_resv;
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		(phase_r == edc_pkg::EDC_READ) |-> (hrdata_o[31:28] == 4'h0) && (hrdata_o[17:15] == 3'h0);
	endproperty
	a_resv: assert property (p_resv) else $error("Reserved bits not zero");
endmodule

// ===== rtl/edc_cfg.svh
`ifndef EDC_CFG_SVH
`define EDC_CFG_SVH
// ----------------------------------------
// Register map
// ----------------------------------------
`define EDC_CAP_WORD_OFS      8'hB4
`define EDC_ADDR_BITS         8
// ----------------------------------------
// Field positions
// ----------------------------------------
`define EDC_MPS_LSB           0
`define EDC_PHANTOM_LSB       3
`define EDC_TAG8_BIT          5
`define EDC_L0S_LSB           6
`define EDC_L1_LSB            9
`define EDC_BUTTON_BIT        12
`define EDC_ATT_IND_BIT       13
`define EDC_PWR_IND_BIT       14
`define EDC_SPL_VAL_LSB       18
`define EDC_SPL_SCL_LSB       26
// ----------------------------------------
// Reset values
// ----------------------------------------
`define EDC_MPS_RST           3'h1
`define EDC_PHANTOM_RST       2'h0
`define EDC_TAG8_RST          1'h1
`define EDC_L0S_RST           3'h0
`define EDC_L1_RST            3'h0
`define EDC_SPL_VAL_RST       8'h00
`define EDC_SPL_SCL_RST       2'h0
`define EDC_PT_FORWARD        4'h7
`define EDC_PT_REVERSE        4'h8
`endif

// ===== rtl/edc_pkg.sv
package edc_pkg;
	// Captured slot power message contents
	typedef struct packed {
		logic [7:0] value;
		logic [1:0] scale;
	} edc_spl_s;
	// Data phase bookkeeping
	typedef enum logic [1:0] {
		EDC_IDLE  = 2'b00,
		EDC_READ  = 2'b01,
		EDC_WRITE = 2'b11
	} edc_phase_e;
endpackage

// ===== verification/edc_msg_src.sv
`timescale 1ns/10ps
// ----------------------------------------
// Upstream port: power limit message source
// ----------------------------------------
module edc_msg_src (
	input  wire logic       clk_i,   // Core clock
	input  wire logic       rst_n_i, // Device reset, active low
	input  wire logic       go_i,    // Send one message now
	input  wire logic [9:0] msg_i,   // Value in 9:2, scale in 1:0
	output logic            valid_o, // One-cycle message pulse
	output logic      [9:0] msg_o    // Message contents
);
	// Pulse one cycle; lines toggle outside messages so stale data never looks valid
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			valid_o <= 1'b0;
			msg_o   <= 10'h000;
		end else begin
			valid_o <= go_i;
			msg_o   <= go_i ? msg_i : ~msg_o;
		end
	end
endmodule

// ===== verification/testbench.sv
`timescale 1ns/10ps
module testbench;
	// ----------------------------------------
	// Stimulus and observation
	// ----------------------------------------
	logic        clk_sys_i = 1'b0;        // Core clock
	logic        rst_n_i   = 1'b0;        // Device reset
	logic        hp, rev, hsel, hwrite, go; // Straps and bus controls
	logic [31:0] haddr, hwdata, got;      // Bus address, data, read result
	logic [1:0]  htrans;                  // Transfer type
	logic [2:0]  hsize;                   // Transfer size
	logic [9:0]  msg;                     // Next power limit message
	wire  logic  sv, rdy, resp;           // Message pulse, ready, response
	wire  logic [7:0]  val;               // Message value
	wire  logic [1:0]  scl;               // Message scale
	wire  logic [3:0]  pt;                // Port type
	wire  logic [31:0] rd;                // Read data
	int          n_errors, n_tests, lf, m_v, m_s, r; // Counters, seed, model
	always #5 clk_sys_i = ~clk_sys_i;
	edc_msg_src u_edc_msg_src (.clk_i(clk_sys_i), .rst_n_i(rst_n_i), .go_i(go), .msg_i(msg),
		.valid_o(sv), .msg_o({val, scl}));
	edc_device_cap u_edc_device_cap (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .hp_strap_i(hp),
		.reverse_i(rev), .spl_valid_i(sv), .spl_value_i(val), .spl_scale_i(scl), .port_type_o(pt),
		.hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize),
		.hwdata_i(hwdata), .hready_i(rdy), .hrdata_o(rd), .hreadyout_o(rdy), .hresp_o(resp));
	// ----------------------------------------
	// Model, compares and bus tasks
	// ----------------------------------------
	// Expected word: fixed codes, hot-plug bits, captured message
	function logic [31:0] ew();
		ew = 32'h00000021 | ((hp & ~rev) ? 32'h00007000 : 32'h0) | 32'(m_v << 18) | 32'(m_s << 26);
	endfunction
	function int nxt(input int x);
		nxt = ((x << 1) | (((x >> 16) ^ (x >> 13)) & 1)) & 32'h1FFFF;
	endfunction
	task end_sim;
		if (n_errors == 0 && n_tests > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	task chk32(input logic [31:0] g, input logic [31:0] e);
		n_tests++;
		if (g !== e) begin
			n_errors++;
			$display("[ERR] %0t word %h expected %h", $time, g, e);
		end
	endtask
	task chk4(input logic [3:0] g, input logic [3:0] e);
		n_tests++;
		if (g !== e) begin
			n_errors++;
			$display("[ERR] %0t port type %h expected %h", $time, g, e);
		end
	endtask
	task chk1(input logic g, input logic e);
		n_tests++;
		if (g !== e) begin
			n_errors++;
			$display("[ERR] %0t response %b expected %b", $time, g, e);
		end
	endtask
	// Bounded wait for ready at a rising edge
	task wrdy;
		int k;
		k = 0;
		do begin
			@(posedge clk_sys_i);
			k++;
		end while (rdy !== 1'b1 && k < 50);
		if (k >= 50) begin
			n_errors++;
			end_sim;
		end
	endtask
	// Single word transfer; writes carry all ones to stress read-only bits
	task bus(input logic [31:0] a, input logic w);
		hsel   <= 1'b1;
		haddr  <= a;
		htrans <= 2'h2;
		hwrite <= w;
		hsize  <= 3'h2;
		wrdy;
		htrans <= 2'h0;
		hsel   <= 1'b0;
		hwdata <= w ? 32'hFFFFFFFF : 32'h0;
		wrdy;
		got = rd;
		chk1(resp, 1'b0);
	endtask
	task rst(input logic h, input logic v);
		rst_n_i <= 1'b0;
		hp      <= h;
		rev     <= v;
		m_v = 0;
		m_s = 0;
		repeat (10) @(posedge clk_sys_i);
		rst_n_i <= 1'b1;
		// Strap and port type both land at the first edge; the second is margin before the checks
		repeat (2) @(posedge clk_sys_i);
	endtask
	// Back-to-back random messages; the model keeps only the last
	task send(input int n);
		repeat (n) begin
			lf = nxt(lf);
			msg <= lf[9:0];
			go  <= 1'b1;
			m_v = lf[9:2];
			m_s = lf[1:0];
			@(posedge clk_sys_i);
		end
		go <= 1'b0;
		repeat (3) @(posedge clk_sys_i);
	endtask
	// ----------------------------------------
	// Main sequence: forward hot-plug, reverse, no hot-plug
	// ----------------------------------------
	initial begin
		{hp, rev, hsel, hwrite, go, haddr, hwdata, htrans, hsize, msg} = '0;
		lf = 89120;
		n_errors = 0;
		n_tests = 0;
		for (r = 0; r < 3; r++) begin
			rst(r != 2, r == 1);
			chk4(pt, rev ? 4'h8 : 4'h7);
			bus(32'h000000B4, 1'b0);
			chk32(got, ew());
			send(1);
			bus(32'h000000B4, 1'b0);
			chk32(got, ew());
			send(2);
			bus(32'h000000B4, 1'b1);
			bus(32'h000000B4, 1'b0);
			chk32(got, ew());
			bus(32'h000000B8, 1'b0);
			chk32(got, 32'h0);
			bus(32'h000100B4, 1'b0);
			chk32(got, 32'h0);
		end
		end_sim;
	end
endmodule
